// *** motor_demand_ctrl.sv ***
// Purpose: Demand-driven torque and speed control, brake, coast, start gating and sync-loss signalling.
// Assumes: Commutator supplies commutation ticks, hold-done and electrical frequency.
// Notes: Registers are reached over APB; the slave answers with no wait state.
// Functional notes
// - Over-limit current forces fixed off-time, then on
// - Demand duty measured 8-bit, upper 4 bits used
// - Torque threshold follows duty, or serial value
// - Idle past two periods turns bridge off
// - One more idle period brakes if enabled
// - Torque brake holds until active, then coast
// - Torque reference ignored until six commutations
// - Idle brake during start aborts the start
// - Low speed flags sync loss, three-low three-high
// - Auto-restart after two patterns, repeating
// - Without restart, fault holds until demand drops
// - Speed reference is duty of maximum frequency
// - Speed loop sets bridge duty from error
// - Speed mode off-time equals bridge period
// - Separate proportional and integral gain codes
// - Speed brake holds until duty exceeds 10%
// - Speed brake only from zero, below 10%
// - Duty 10-25% coasts, above 25% starts
// - Speed reference ignored until two commutations
// - Speed low: all bridge off, then fault
// - Speed restart only above 25% demand
// - Inactive demand level follows invert setting
// - Brake turns on all low-side transistors
//
// The APB interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "motor_ctrl_regs.svh"
module motor_demand_ctrl
  import motor_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic demand_in,
  input wire logic current_over,
  input wire logic comm_tick,
  input wire logic hold_done,
  input wire logic [15:0] elec_freq,
  output logic [3:0] current_limit_threshold,
  output logic bridge_on,
  output logic bridge_coast,
  output logic brake_low_side,
  output logic start_req,
  output logic fault_out_n,
  output logic fault_oe_n
);
  typedef struct packed {
    logic [5:0] ctrl;
    logic [4:0] chop;
    logic [2:0] smx;
    logic [2:0] sp;
    logic [2:0] si;
    logic [3:0] ilim;
    logic [15:0] start_spd;
    logic [31:0] rdata;
    ctrl_state_e st;
    logic zero_seen;
    logic settle_go;
    logic [2:0] settle;
    logic [2:0] phase;
    logic [1:0] reps;
    logic [10:0] off_cnt;
    logic [10:0] pc;
    logic [3:0] thr;
    logic bridge_on;
    logic brake;
    logic coast;
    logic start;
    logic fault_n;
  } ctrl_s;

  ctrl_s r, next_r;
  logic [7:0] duty;
  logic period_tick, dem_active, idle_off, idle_brake;
  logic speed_mode, motor_en, brake_en, restart_en;
  logic [15:0] speed_ref;
  logic [7:0] pi_duty;
  logic [10:0] chop_cyc;
  logic [18:0] on_prod;
  logic low_speed, pc_wrap, mapped, wr, rd_setup;

  function automatic logic addr_is(input logic [7:0] a, input logic [7:0] off);
    addr_is = (a == off);
  endfunction

  assign speed_mode = r.ctrl[`CTRL_MODE];
  assign motor_en = r.ctrl[`CTRL_MOTOR_EN];
  assign brake_en = r.ctrl[`CTRL_BRAKE_EN];
  assign restart_en = r.ctrl[`CTRL_RESTART];
  assign chop_cyc = 11'((r.chop + 6'd1) * `CHOP_UNIT_CYC);
  assign on_prod = pi_duty * chop_cyc;
  assign pc_wrap = (r.pc >= chop_cyc - 11'd1);
  // Sync is lost when speed or, in speed mode, the demand falls under a quarter of start speed.
  assign low_speed = (elec_freq < (r.start_spd >> 2))
    || (speed_mode && speed_ref < (r.start_spd >> 2));

  assign mapped = addr_is(paddr, `REG_CTRL) || addr_is(paddr, `REG_CFG) || addr_is(paddr, `REG_ILIM)
    || addr_is(paddr, `REG_START) || addr_is(paddr, `REG_STATUS);
  assign wr = psel && penable && pwrite && mapped;
  assign rd_setup = psel && !penable;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = r.rdata;

  assign current_limit_threshold = r.thr;
  assign bridge_on = r.bridge_on;
  assign bridge_coast = r.coast;
  assign brake_low_side = r.brake;
  assign start_req = r.start;
  assign fault_out_n = r.fault_n;
  // The pin is open drain: enable low while pulling it low.
  assign fault_oe_n = r.fault_n;

  demand_meter u_meter (
    .clk(clk),
    .rstn(rstn),
    .demand_in(demand_in),
    .invert(r.ctrl[`CTRL_INVERT]),
    .duty(duty),
    .period_tick(period_tick),
    .active(dem_active),
    .idle_off(idle_off),
    .idle_brake(idle_brake)
  );

  speed_pi u_pi (
    .clk(clk),
    .rstn(rstn),
    .enable(speed_mode && r.st == st_run),
    .update(pc_wrap),
    .duty(duty),
    .elec_freq(elec_freq),
    .max_speed_code(r.smx),
    .prop_gain_code(r.sp),
    .int_gain_code(r.si),
    .speed_ref(speed_ref),
    .bridge_duty(pi_duty)
  );

  always_comb begin
    next_r = r;
    next_r.start = 1'b0;
    // Register writes take effect on the access phase.
    if (wr && addr_is(paddr, `REG_CTRL)) begin
      next_r.ctrl = pwdata[5:0];
    end
    if (wr && addr_is(paddr, `REG_CFG)) begin
      next_r.chop = pwdata[`CFG_CHOP_LSB +: 5];
      next_r.smx = pwdata[`CFG_SMX_LSB +: 3];
      next_r.sp = pwdata[`CFG_SP_LSB +: 3];
      next_r.si = pwdata[`CFG_SI_LSB +: 3];
    end
    if (wr && addr_is(paddr, `REG_ILIM)) begin
      next_r.ilim = pwdata[3:0];
    end
    if (wr && addr_is(paddr, `REG_START)) begin
      next_r.start_spd = pwdata[15:0];
    end
    if (rd_setup) begin
      next_r.rdata = 32'h0000_0000;
      if (addr_is(paddr, `REG_CTRL)) begin
        next_r.rdata = {26'h0, r.ctrl};
      end
      if (addr_is(paddr, `REG_CFG)) begin
        next_r.rdata = {13'h0, r.si, 1'b0, r.sp, 1'b0, r.smx, 3'h0, r.chop};
      end
      if (addr_is(paddr, `REG_ILIM)) begin
        next_r.rdata = {28'h0, r.ilim};
      end
      if (addr_is(paddr, `REG_START)) begin
        next_r.rdata = {16'h0, r.start_spd};
      end
      if (addr_is(paddr, `REG_STATUS)) begin
        next_r.rdata = {12'h0, low_speed, 3'(r.st), duty, r.fault_n, r.coast, r.brake, r.bridge_on, r.thr};
      end
    end

    // Zero demand arms the speed-mode brake; a duty above 10% disarms it.
    if (idle_off) begin
      next_r.zero_seen = 1'b1;
    end else if (duty > `DUTY_10) begin
      next_r.zero_seen = 1'b0;
    end

    case (r.st)
      st_brake: begin
        if (!speed_mode && dem_active) begin
          next_r.st = st_coast;
          if (motor_en && !brake_en) begin
            next_r.st = st_start;
            next_r.start = 1'b1;
          end
        end else if (speed_mode && !idle_off && duty > `DUTY_10) begin
          next_r.st = st_coast;
        end else if (!(brake_en && motor_en)) begin
          next_r.st = st_coast;
        end
      end
      st_coast: begin
        if (idle_brake && brake_en && motor_en) begin
          next_r.st = st_brake;
        end else if (speed_mode && r.zero_seen && !idle_off && brake_en && motor_en) begin
          next_r.st = st_brake;
        end else if (motor_en && !brake_en && !speed_mode && dem_active && !idle_off) begin
          next_r.st = st_start;
          next_r.start = 1'b1;
        end else if (motor_en && speed_mode && !idle_off && duty > `DUTY_25) begin
          next_r.st = st_start;
          next_r.start = 1'b1;
        end
      end
      st_start: begin
        if (hold_done) begin
          next_r.settle_go = 1'b1;
        end
        if (r.settle_go && comm_tick) begin
          next_r.settle = r.settle + 3'd1;
        end
        if (r.settle == (speed_mode ? `SPEED_SETTLE : `TORQUE_SETTLE)) begin
          next_r.st = st_run;
        end
        if (idle_brake) begin
          next_r.st = (brake_en && motor_en) ? st_brake : st_coast;
        end else if (!motor_en) begin
          next_r.st = st_coast;
        end
      end
      st_run: begin
        if (idle_brake) begin
          next_r.st = (brake_en && motor_en) ? st_brake : st_coast;
        end else if (!motor_en) begin
          next_r.st = st_coast;
        end else if (low_speed && !idle_off) begin
          next_r.st = st_los;
          next_r.phase = 3'd0;
          next_r.reps = 2'd0;
        end
      end
      st_los: begin
        if (period_tick) begin
          next_r.phase = (r.phase == 2 * `FAULT_HALF - 1) ? 3'd0 : r.phase + 3'd1;
          if (r.phase == 2 * `FAULT_HALF - 1) begin
            next_r.reps = r.reps + 2'd1;
          end
        end
        if (!motor_en) begin
          next_r.st = st_coast;
        end else if (idle_brake) begin
          next_r.st = brake_en ? st_brake : st_coast;
        end else if (restart_en && r.reps == `FAULT_REPEATS) begin
          if (speed_mode ? (duty > `DUTY_25) : !idle_off) begin
            next_r.st = st_start;
            next_r.start = 1'b1;
          end
        end else if (!restart_en && (speed_mode ? (duty < `DUTY_25) : idle_off)) begin
          next_r.st = st_coast;
        end
      end
      default: begin
        next_r.st = st_brake;
      end
    endcase

    if (next_r.st != st_start) begin
      next_r.settle = 3'd0;
      next_r.settle_go = 1'b0;
    end

    // Current threshold: in torque mode held during a start, otherwise from duty or the serial value; in speed mode the serial value.
    if (!speed_mode && r.st != st_start) begin
      next_r.thr = r.ctrl[`CTRL_SER_ILIM] ? r.ilim : duty[7:4];
    end else if (speed_mode) begin
      next_r.thr = r.ilim;
    end

    // Bridge switching: period counter and fixed off-time regulator.
    next_r.pc = pc_wrap ? 11'd0 : r.pc + 11'd1;
    if (r.off_cnt != 11'd0) begin
      next_r.off_cnt = r.off_cnt - 11'd1;
    end else if (current_over && r.bridge_on) begin
      next_r.off_cnt = chop_cyc;
    end
    next_r.bridge_on = 1'b0;
    if ((r.st == st_start || r.st == st_run) && !idle_off && r.off_cnt == 11'd0) begin
      if (speed_mode && r.st == st_run) begin
        next_r.bridge_on = (pi_duty == 8'hff) || (r.pc < on_prod[18:8]);
      end else begin
        next_r.bridge_on = 1'b1;
      end
    end
    next_r.brake = (r.st == st_brake) && brake_en && motor_en;
    next_r.coast = !next_r.brake && !next_r.bridge_on
      && (r.st == st_coast || r.st == st_los || (r.st == st_brake));
    next_r.fault_n = (r.st == st_los) ? (r.phase >= `FAULT_HALF) : 1'b1;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      r <= '0;
      r.ctrl <= `CTRL_RST;
      r.chop <= 5'(`CFG_RST >> `CFG_CHOP_LSB);
      r.smx <= 3'(`CFG_RST >> `CFG_SMX_LSB);
      r.sp <= 3'(`CFG_RST >> `CFG_SP_LSB);
      r.si <= 3'(`CFG_RST >> `CFG_SI_LSB);
      r.ilim <= `ILIM_RST;
      r.start_spd <= `START_RST;
      r.st <= st_brake;
      r.fault_n <= 1'b1;
    end else begin
      r <= next_r;
    end
  end
endmodule
`default_nettype wire

// *** motor_ctrl_regs.svh ***
// Purpose: Offsets, field positions, reset values and timing counts of the demand controller.
// Assumes: 50 MHz system clock.
// Notes: Included by the package, the controller, the demand meter and the bench.
`ifndef MOTOR_CTRL_REGS_SVH
`define MOTOR_CTRL_REGS_SVH
`define REG_CTRL 8'h00
`define REG_CFG 8'h04
`define REG_ILIM 8'h08
`define REG_START 8'h0c
`define REG_STATUS 8'h10
`define CTRL_MODE 0
`define CTRL_MOTOR_EN 1
`define CTRL_BRAKE_EN 2
`define CTRL_RESTART 3
`define CTRL_INVERT 4
`define CTRL_SER_ILIM 5
`define CFG_CHOP_LSB 0
`define CFG_SMX_LSB 8
`define CFG_SP_LSB 12
`define CFG_SI_LSB 16
`define CTRL_RST 6'h00
`define CFG_RST 32'h0004_401f
`define ILIM_RST 4'hf
`define START_RST 16'h0064
`define CLK_PERIOD_NS 20
`define CHOP_UNIT_NS 1000
`define CHOP_UNIT_CYC ((`CHOP_UNIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DUTY_10 8'd25
`define DUTY_25 8'd64
`define TORQUE_SETTLE 3'd6
`define SPEED_SETTLE 3'd2
`define FAULT_HALF 3'd3
`define FAULT_REPEATS 2'd2
`define METER_W 24
`endif

// *** motor_ctrl_pkg.sv ***
// Purpose: Shared types of the demand controller.
// Assumes: Constants come from motor_ctrl_regs.svh.
// Notes: States carry no fixed codes.
`include "motor_ctrl_regs.svh"
package motor_ctrl_pkg;
  typedef enum logic [2:0] {st_brake, st_coast, st_start, st_run, st_los} ctrl_state_e;
  typedef struct packed {
    logic s1;
    logic s2;
    logic act_prev;
    logic started;
    logic [`METER_W-1:0] hi_cnt;
    logic [`METER_W-1:0] per_cnt;
    logic [`METER_W-1:0] last_per;
    logic [`METER_W+1:0] idle_cnt;
    logic busy;
    logic [3:0] step;
    logic [`METER_W:0] rem;
    logic [7:0] quo;
    logic [7:0] duty;
    logic tick;
  } meter_s;
  typedef struct packed {
    logic signed [23:0] integ;
    logic [7:0] out;
  } pi_s;
endpackage

// *** demand_meter.sv ***
// Purpose: Synchronises the demand input and measures its duty and idle time.
// Assumes: One period runs from one active edge to the next.
// Notes: Duty is active cycles times 256 over period cycles, found by serial division.
`timescale 1ns/1ps
`default_nettype none
`include "motor_ctrl_regs.svh"
module demand_meter
  import motor_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic demand_in,
  input wire logic invert,
  output logic [7:0] duty,
  output logic period_tick,
  output logic active,
  output logic idle_off,
  output logic idle_brake
);
  localparam logic [`METER_W-1:0] CNT_MAX = '1;
  // The edge cycle is itself active and part of the period, so both counts restart at one.
  localparam logic [`METER_W-1:0] CNT_ONE = {{(`METER_W-1){1'b0}}, 1'b1};
  meter_s r, next_r;
  logic act;
  logic [`METER_W+1:0] two_per, three_per;

  assign act = r.s2 ^ invert;
  assign two_per = {1'b0, r.last_per, 1'b0};
  assign three_per = two_per + {2'b00, r.last_per};
  assign duty = r.duty;
  assign period_tick = r.tick;
  assign active = act;
  // No measured period yet means idle is taken as long, so idle_off and idle_brake rise one cycle after reset while demand is inactive.
  assign idle_off = !act && (r.idle_cnt > two_per);
  assign idle_brake = !act && (r.idle_cnt > three_per);

  always_comb begin
    next_r = r;
    next_r.s1 = demand_in;
    next_r.s2 = r.s1;
    next_r.act_prev = act;
    next_r.tick = 1'b0;
    if (r.per_cnt != CNT_MAX) begin
      next_r.per_cnt = r.per_cnt + 1'b1;
    end
    if (act && r.hi_cnt != CNT_MAX) begin
      next_r.hi_cnt = r.hi_cnt + 1'b1;
    end
    if (act || r.idle_cnt[`METER_W+1]) begin
      next_r.idle_cnt = act ? '0 : r.idle_cnt;
    end else begin
      next_r.idle_cnt = r.idle_cnt + 1'b1;
    end
    if (act && !r.act_prev) begin
      next_r.per_cnt = CNT_ONE;
      next_r.hi_cnt = CNT_ONE;
      next_r.started = 1'b1;
      if (r.started && r.per_cnt != '0) begin
        next_r.last_per = r.per_cnt;
        next_r.rem = {1'b0, r.hi_cnt};
        next_r.busy = 1'b1;
        next_r.step = 4'h0;
        next_r.quo = 8'h00;
      end
    end
    if (r.busy) begin
      if (r.step == 4'h8) begin
        next_r.busy = 1'b0;
        next_r.duty = r.quo;
        next_r.duty = (r.rem >= {1'b0, r.last_per}) ? 8'hff : next_r.duty;
        next_r.tick = 1'b1;
      end else begin
        next_r.step = r.step + 1'b1;
        if ({r.rem[`METER_W-1:0], 1'b0} >= {1'b0, r.last_per}) begin
          next_r.rem = {r.rem[`METER_W-1:0], 1'b0} - {1'b0, r.last_per};
          next_r.quo = {r.quo[6:0], 1'b1};
        end else begin
          next_r.rem = {r.rem[`METER_W-1:0], 1'b0};
          next_r.quo = {r.quo[6:0], 1'b0};
        end
      end
    end
    // A remainder already at or above the period ends the division at once with full duty.
    if (r.busy && r.step == 4'h0 && r.rem >= {1'b0, r.last_per}) begin
      next_r.quo = 8'hff;
      next_r.step = 4'h8;
      next_r.rem = {1'b0, r.last_per};
    end
    if (idle_off) begin
      next_r.duty = 8'h00;
    end
    if (act && r.hi_cnt > r.last_per && r.last_per != '0) begin
      next_r.duty = 8'hff;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
endmodule
`default_nettype wire

// *** speed_pi.sv ***
// Purpose: Proportional-integral speed loop giving the bridge duty.
// Assumes: Frequencies in 0.1 Hz units; update pulses once per bridge period.
// Notes: The integrator holds while disabled so a start does not wind it up.
`timescale 1ns/1ps
`default_nettype none
module speed_pi
  import motor_ctrl_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic enable,
  input wire logic update,
  input wire logic [7:0] duty,
  input wire logic [15:0] elec_freq,
  input wire logic [2:0] max_speed_code,
  input wire logic [2:0] prop_gain_code,
  input wire logic [2:0] int_gain_code,
  output logic [15:0] speed_ref,
  output logic [7:0] bridge_duty
);
  pi_s r, next_r;
  logic [15:0] max_electrical_freq;
  logic [23:0] prod;
  logic signed [23:0] err, p_term, sum;

  assign max_electrical_freq = 16'((17'h1 << (max_speed_code + 4'd8)) - 17'h1);
  assign prod = duty * max_electrical_freq;
  assign speed_ref = prod[23:8];
  assign err = $signed({8'h00, speed_ref}) - $signed({8'h00, elec_freq});
  assign p_term = (err <<< prop_gain_code) >>> 3;
  assign sum = p_term + (r.integ >>> 4);
  assign bridge_duty = r.out;

  always_comb begin
    next_r = r;
    if (enable && update) begin
      next_r.integ = r.integ + (err >>> (3'd7 - int_gain_code));
      if (sum < 0) begin
        next_r.out = 8'h00;
      end else if (sum > 24'sd255) begin
        next_r.out = 8'hff;
      end else begin
        next_r.out = sum[7:0];
      end
      if (next_r.integ > 24'sh0fffff || next_r.integ < -24'sh0fffff) begin
        next_r.integ = r.integ;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
endmodule
`default_nettype wire

// *** demand_source.sv ***
// Purpose: Model of the external controller that drives the demand input.
// Assumes: Runs on the system clock; period and active time are given in clock cycles.
// Notes: It stops only at the end of a period, so the last measured period is always whole.
`timescale 1ns/1ps
`default_nettype none
module demand_source #(
  parameter int PERIOD_CYC = 50000,
  parameter int HIGH_CYC = 37500
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic enable,
  input wire logic invert,
  output logic demand
);
  int cnt;
  logic run;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt <= 0;
      run <= 1'b0;
    end else if (run && cnt < PERIOD_CYC - 1) begin
      cnt <= cnt + 1;
    end else begin
      cnt <= 0;
      run <= enable;
    end
  end
  // The default period is 1 kHz at 50 MHz, the fastest legal rate; a bench may shorten it to save run time.
  assign demand = (run && cnt < HIGH_CYC) ^ invert;
endmodule
`default_nettype wire

// *** motor_demand_ctrl_assertions.sv ***
// Purpose: Port-level checks of the demand controller.
// Assumes: One clock domain, reset asynchronous and active low.
// Notes: Bound to every instance of motor_demand_ctrl.
`timescale 1ns/1ps
`default_nettype none
module motor_demand_ctrl_assertions (
  input wire logic clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic demand_in,
  input wire logic current_over,
  input wire logic comm_tick,
  input wire logic hold_done,
  input wire logic [15:0] elec_freq,
  input wire logic [3:0] current_limit_threshold,
  input wire logic bridge_on,
  input wire logic bridge_coast,
  input wire logic brake_low_side,
  input wire logic start_req,
  input wire logic fault_out_n,
  input wire logic fault_oe_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_pready; pready; endproperty
  a_pready: assert property (p_pready) else $error("pready dropped");
  property p_refuse; pslverr |-> psel && penable && prdata == 32'h0; endproperty
  a_refuse: assert property (p_refuse) else $error("error response outside access or with data");
  property p_fault_pin; fault_oe_n == fault_out_n; endproperty
  a_fault_pin: assert property (p_fault_pin) else $error("fault pin enable differs from fault");
  property p_brake; brake_low_side |-> !bridge_on && !bridge_coast; endproperty
  a_brake: assert property (p_brake) else $error("brake overlaps drive or coast");
  property p_coast; bridge_coast |-> !bridge_on; endproperty
  a_coast: assert property (p_coast) else $error("coast with bridge on");
  property p_start; start_req |=> !start_req; endproperty
  a_start: assert property (p_start) else $error("start request longer than one cycle");
  property p_chop; bridge_on && current_over |-> ##[1:2] !bridge_on; endproperty
  a_chop: assert property (p_chop) else $error("over-limit current did not turn bridge off");
  property p_offtime; $fell(bridge_on) && $past(current_over && bridge_on, 2) |-> !bridge_on [*8]; endproperty
  a_offtime: assert property (p_offtime) else $error("off-time cut short");
endmodule
bind motor_demand_ctrl motor_demand_ctrl_assertions motor_demand_ctrl_assertions_inst (.clk, .rstn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .demand_in, .current_over, .comm_tick,
  .hold_done, .elec_freq, .current_limit_threshold, .bridge_on, .bridge_coast, .brake_low_side, .start_req,
  .fault_out_n, .fault_oe_n);
`default_nettype wire

// *** tb_motor_demand_ctrl.sv ***
// Purpose: Self-checking bench of motor_demand_ctrl in torque mode.
// Assumes: 50 MHz clock, demand of 2000-cycle period and 75% duty from demand_source.
// Notes: The demand runs far faster than the legal rate to keep the run short; the meter only sees ratios.
`timescale 1ns/1ps
`default_nettype none
`include "motor_ctrl_regs.svh"
module tb_motor_demand_ctrl;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, demand_in, bridge_on, bridge_coast, brake_low_side, start_req, fault_out_n, fault_oe_n;
  logic current_over = 1'b0;
  logic comm_tick = 1'b0;
  logic hold_done = 1'b0;
  logic dem_en = 1'b0;
  logic [15:0] elec_freq = 16'h03e8;
  logic [3:0] current_limit_threshold;
  logic [31:0] rd;
  logic err;
  int n_errors = 0;
  int n_tests = 0;
  int cyc = 0;
  int i;
  localparam int DEM_PER = 2000;
  localparam int DEM_HI = 1500;
  localparam logic [7:0] EXP_DUTY = 8'(DEM_HI * 256 / DEM_PER);
  motor_demand_ctrl motor_demand_ctrl_inst (.clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .demand_in, .current_over, .comm_tick, .hold_done, .elec_freq, .current_limit_threshold,
    .bridge_on, .bridge_coast, .brake_low_side, .start_req, .fault_out_n, .fault_oe_n);
  demand_source #(.PERIOD_CYC(DEM_PER), .HIGH_CYC(DEM_HI)) demand_source_inst (.clk, .rstn, .enable(dem_en),
    .invert(1'b0), .demand(demand_in));
  initial forever #10 clk = ~clk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test();
    if (n_errors == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Holds the request until pready is sampled high, then takes data and response at that same edge.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic settle(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wait_level(input logic lvl);
    for (int k = 0; k < 3000 && demand_in !== lvl; k++) @(negedge clk);
  endtask
  task automatic comm(input int n);
    repeat (n) begin
      @(posedge clk);
      comm_tick <= 1'b1;
      @(posedge clk);
      comm_tick <= 1'b0;
      repeat (8) @(posedge clk);
    end
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      finish_test();
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    settle(1);
    check(current_limit_threshold, 4'h0, "thr_reset");
    check(fault_out_n, 1'b1, "fault_reset");
    apb(1'b0, `REG_CTRL, 32'h0);
    check(rd, `CTRL_RST, "ctrl_reset");
    apb(1'b0, `REG_CFG, 32'h0);
    check(rd, `CFG_RST, "cfg_reset");
    apb(1'b0, `REG_ILIM, 32'h0);
    check(rd, `ILIM_RST, "ilim_reset");
    apb(1'b0, `REG_START, 32'h0);
    check(rd, `START_RST, "start_reset");
    apb(1'b0, 8'h14, 32'h0);
    check(err, 1'b1, "unmapped_err");
    check(rd, 32'h0, "unmapped_data");
    // Chop code 0 gives the shortest off-time, one chop unit.
    apb(1'b1, `REG_CFG, 32'h0004_4000);
    settle(4);
    check(bridge_coast, 1'b1, "coast_idle");
    check(brake_low_side, 1'b0, "brake_idle");
    // The motor stays disabled until a whole demand period has been measured.
    @(posedge clk);
    dem_en <= 1'b1;
    wait_level(1'b1);
    wait_level(1'b0);
    wait_level(1'b1);
    settle(40);
    apb(1'b1, `REG_CTRL, 32'h2);
    for (i = 0; i < 500 && start_req !== 1'b1; i++) @(negedge clk);
    check(start_req, 1'b1, "start_req");
    @(posedge clk);
    hold_done <= 1'b1;
    @(posedge clk);
    hold_done <= 1'b0;
    comm(5);
    apb(1'b1, `REG_ILIM, 32'h5);
    apb(1'b1, `REG_CTRL, 32'h22);
    settle(4);
    check(current_limit_threshold, EXP_DUTY[7:4], "thr_during_start");
    comm(1);
    settle(1);
    check(current_limit_threshold, 4'h5, "thr_serial");
    apb(1'b1, `REG_CTRL, 32'h2);
    settle(4);
    check(current_limit_threshold, EXP_DUTY[7:4], "thr_duty");
    check(bridge_on, 1'b1, "run_on");
    @(posedge clk);
    current_over <= 1'b1;
    @(posedge clk);
    current_over <= 1'b0;
    for (i = 0; i < 5 && bridge_on !== 1'b0; i++) @(negedge clk);
    for (i = 0; i < 200 && bridge_on !== 1'b1; i++) @(negedge clk);
    check(i, `CHOP_UNIT_CYC, "off_time");
    apb(1'b0, `REG_STATUS, 32'h0);
    check(rd[15:8], EXP_DUTY, "duty");
    apb(1'b1, `REG_CTRL, 32'h6);
    dem_en <= 1'b0;
    wait_level(1'b0);
    // Idle began at most one low phase ago, so this lies past two periods and short of three.
    settle(2 * DEM_PER + DEM_PER / 4);
    check(bridge_on, 1'b0, "idle_off");
    check(brake_low_side, 1'b0, "brake_wait");
    settle(DEM_PER);
    check(brake_low_side, 1'b1, "idle_brake");
    @(posedge clk);
    dem_en <= 1'b1;
    settle(10);
    check(brake_low_side, 1'b0, "brake_release");
    check(bridge_coast, 1'b1, "coast_after_brake");
    finish_test();
  end
endmodule
`default_nettype wire
